// File: logic/timer_two_control_reload.sv
// Control, status and reload logic of the second 16-bit timer, with its counter bytes.
// Assumes a core issuing one-cycle read/write/bit-write strobes; external and slow
// oscillator inputs are asynchronous and are synchronised here.
module timer_two_control_reload (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire timer_two_pkg::sfr_req_type sfr_req,
  output logic [7:0] sfr_rdata,
  input wire logic timer_irq_enable,
  input wire logic high_byte_fast_clock_sel,
  input wire logic low_byte_fast_clock_sel,
  input wire logic ext_osc_clk,
  input wire logic slow_osc_clk,
  output logic timer_irq_req
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic [7:0] control_reg;
  logic [7:0] control_next;
  logic [7:0] reload_low_byte_reg;
  logic [7:0] reload_high_byte_reg;
  logic [7:0] counter_low_byte_reg;
  logic [7:0] counter_high_byte_reg;
  logic [3:0] sys_div_reg;
  logic [2:0] ext_div_reg;
  logic [2:0] ext_sync_reg;
  logic [2:0] slow_sync_reg;
  logic [7:0] sfr_rdata_reg;
  logic timer_irq_reg;
  logic sys_tick;
  logic ext_tick;
  logic sel_tick;
  logic low_tick;
  logic high_tick;
  logic split;
  logic run;
  logic low_wrap;
  logic high_wrap;
  logic full_wrap;
  logic capture;
  logic ctrl_wr;
  logic [7:0] ctrl_wdata;
  logic [7:0] ctrl_mask;
  logic count_low_wr;
  logic count_high_wr;
  logic reload_low_wr;
  logic reload_high_wr;
  logic low_step;
  logic high_step;
  logic ext_rise;
  logic slow_fall;
  logic irq_pending;
  logic [7:0] read_value;

  // Decodes an access to one register address.
  function automatic logic hit(input timer_two_pkg::sfr_req_type req, input logic [7:0] addr);
    hit = req.addr == addr;
  endfunction

  // ------------------------------------------------------------
  // Clock sources
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sys_div_reg <= 4'h0;
    end else if (sys_div_reg == timer_two_pkg::SYS_DIV_LAST) begin
      sys_div_reg <= 4'h0;
    end else begin
      sys_div_reg <= sys_div_reg + 4'h1;
    end
  end

  // ------------------------------------------------------------
  // Synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ext_sync_reg <= 3'h0;
    end else begin
      ext_sync_reg <= {ext_sync_reg[1:0], ext_osc_clk};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      slow_sync_reg <= 3'h0;
    end else begin
      slow_sync_reg <= {slow_sync_reg[1:0], slow_osc_clk};
    end
  end

  assign ext_rise = ext_sync_reg[1] && !ext_sync_reg[2];
  assign slow_fall = !slow_sync_reg[1] && slow_sync_reg[2];

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ext_div_reg <= 3'h0;
    end else if (ext_rise) begin
      ext_div_reg <= ext_div_reg + 3'h1;
    end
  end

  assign sys_tick = sys_div_reg == timer_two_pkg::SYS_DIV_LAST;
  assign ext_tick = ext_rise && ext_div_reg == timer_two_pkg::EXT_DIV_LAST;
  assign split = control_reg[timer_two_pkg::SPLIT_BIT];
  assign run = control_reg[timer_two_pkg::RUN_BIT];

  // ------------------------------------------------------------
  // Tick selection
  // ------------------------------------------------------------
  always_comb begin
    sel_tick = sys_tick;
    if (control_reg[timer_two_pkg::EXT_CLK_BIT]) begin
      sel_tick = ext_tick;
    end
  end

  always_comb begin
    low_tick = sel_tick;
    if (low_byte_fast_clock_sel) begin
      low_tick = 1'b1;
    end
  end

  always_comb begin
    high_tick = low_tick;
    if (split) begin
      high_tick = sel_tick;
      if (high_byte_fast_clock_sel) begin
        high_tick = 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Counter events
  // ------------------------------------------------------------
  always_comb begin
    capture = 1'b0;
    if (control_reg[timer_two_pkg::CAPTURE_EN_BIT]) begin
      capture = slow_fall;
    end
  end

  always_comb begin
    low_step = low_tick && (run || split);
    low_wrap = low_step && counter_low_byte_reg == timer_two_pkg::BYTE_MAX;
    full_wrap = 1'b0;
    high_step = 1'b0;
    high_wrap = 1'b0;
    if (split) begin
      high_step = run && high_tick;
      high_wrap = high_step && counter_high_byte_reg == timer_two_pkg::BYTE_MAX;
    end else begin
      full_wrap = low_wrap && counter_high_byte_reg == timer_two_pkg::BYTE_MAX;
      high_step = low_wrap;
      high_wrap = full_wrap;
    end
  end

  // ------------------------------------------------------------
  // Write decode
  // ------------------------------------------------------------
  assign count_low_wr = sfr_req.wr && hit(sfr_req, timer_two_pkg::COUNT_LOW_ADDR);
  assign count_high_wr = sfr_req.wr && hit(sfr_req, timer_two_pkg::COUNT_HIGH_ADDR);
  assign reload_low_wr = sfr_req.wr && hit(sfr_req, timer_two_pkg::RELOAD_LOW_ADDR);
  assign reload_high_wr = sfr_req.wr && hit(sfr_req, timer_two_pkg::RELOAD_HIGH_ADDR);

  // ------------------------------------------------------------
  // Counter bytes
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      counter_low_byte_reg <= timer_two_pkg::BYTE_RESET;
    end else if (count_low_wr) begin
      counter_low_byte_reg <= sfr_req.wdata;
    end else if (full_wrap || (split && low_wrap)) begin
      counter_low_byte_reg <= reload_low_byte_reg;
    end else if (low_step) begin
      counter_low_byte_reg <= counter_low_byte_reg + 8'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      counter_high_byte_reg <= timer_two_pkg::BYTE_RESET;
    end else if (count_high_wr) begin
      counter_high_byte_reg <= sfr_req.wdata;
    end else if (high_wrap) begin
      counter_high_byte_reg <= reload_high_byte_reg;
    end else if (high_step) begin
      counter_high_byte_reg <= counter_high_byte_reg + 8'h01;
    end
  end

  // ------------------------------------------------------------
  // Reload registers
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      reload_low_byte_reg <= timer_two_pkg::BYTE_RESET;
    end else if (capture) begin
      reload_low_byte_reg <= counter_low_byte_reg;
    end else if (reload_low_wr) begin
      reload_low_byte_reg <= sfr_req.wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      reload_high_byte_reg <= timer_two_pkg::BYTE_RESET;
    end else if (capture) begin
      reload_high_byte_reg <= counter_high_byte_reg;
    end else if (reload_high_wr) begin
      reload_high_byte_reg <= sfr_req.wdata;
    end
  end

  // ------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------
  assign ctrl_wr = (sfr_req.wr || sfr_req.bit_wr) && hit(sfr_req, timer_two_pkg::CONTROL_ADDR);

  always_comb begin
    ctrl_mask = 8'hFF;
    ctrl_wdata = sfr_req.wdata;
    if (sfr_req.bit_wr) begin
      ctrl_mask = 8'h01 << sfr_req.bit_sel;
      ctrl_wdata = {8{sfr_req.wdata[0]}};
    end
  end

  always_comb begin
    control_next = control_reg;
    if (ctrl_wr) begin
      control_next = (control_reg & ~(ctrl_mask & timer_two_pkg::CONTROL_WRITE_MASK)) |
        (ctrl_wdata & ctrl_mask & timer_two_pkg::CONTROL_WRITE_MASK);
    end
    if (high_wrap || capture) begin
      control_next[timer_two_pkg::HIGH_FLAG_BIT] = 1'b1;
    end
    if (low_wrap) begin
      control_next[timer_two_pkg::LOW_FLAG_BIT] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      control_reg <= timer_two_pkg::CONTROL_RESET;
    end else begin
      control_reg <= control_next;
    end
  end

  // ------------------------------------------------------------
  // Interrupt request
  // ------------------------------------------------------------
  always_comb begin
    irq_pending = 1'b0;
    if (control_reg[timer_two_pkg::HIGH_FLAG_BIT]) begin
      irq_pending = 1'b1;
    end
    if (control_reg[timer_two_pkg::LOW_IRQ_EN_BIT] &&
        control_reg[timer_two_pkg::LOW_FLAG_BIT]) begin
      irq_pending = 1'b1;
    end
    if (!timer_irq_enable) begin
      irq_pending = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      timer_irq_reg <= 1'b0;
    end else begin
      timer_irq_reg <= irq_pending;
    end
  end

  assign timer_irq_req = timer_irq_reg;

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  always_comb begin
    case (sfr_req.addr)
      timer_two_pkg::CONTROL_ADDR: begin
        read_value = control_reg & timer_two_pkg::CONTROL_WRITE_MASK;
      end
      timer_two_pkg::RELOAD_LOW_ADDR: begin
        read_value = reload_low_byte_reg;
      end
      timer_two_pkg::RELOAD_HIGH_ADDR: begin
        read_value = reload_high_byte_reg;
      end
      timer_two_pkg::COUNT_LOW_ADDR: begin
        read_value = counter_low_byte_reg;
      end
      timer_two_pkg::COUNT_HIGH_ADDR: begin
        read_value = counter_high_byte_reg;
      end
      default: begin
        read_value = 8'h00;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sfr_rdata_reg <= 8'h00;
    end else if (sfr_req.rd) begin
      sfr_rdata_reg <= read_value;
    end
  end

  assign sfr_rdata = sfr_rdata_reg;

endmodule // timer_two_control_reload

// File: shared/timer_two_pkg.sv
// Package for the second general-purpose timer: register map, bit layout, timing counts.
// Assumes a byte-wide special-function-register bus on a single 200 MHz system clock.
package timer_two_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] CONTROL_ADDR = 8'hC8;
  localparam logic [7:0] RELOAD_LOW_ADDR = 8'hCA;
  localparam logic [7:0] RELOAD_HIGH_ADDR = 8'hCB;
  localparam logic [7:0] COUNT_LOW_ADDR = 8'hCC;
  localparam logic [7:0] COUNT_HIGH_ADDR = 8'hCD;

  // ------------------------------------------------------------
  // Control register bit positions and reset values
  // ------------------------------------------------------------
  localparam int HIGH_FLAG_BIT = 7;
  localparam int LOW_FLAG_BIT = 6;
  localparam int LOW_IRQ_EN_BIT = 5;
  localparam int CAPTURE_EN_BIT = 4;
  localparam int SPLIT_BIT = 3;
  localparam int RUN_BIT = 2;
  localparam int UNUSED_BIT = 1;
  localparam int EXT_CLK_BIT = 0;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONTROL_WRITE_MASK = 8'hFD;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] BYTE_MAX = 8'hFF;

  // ------------------------------------------------------------
  // Clock division
  // ------------------------------------------------------------
  localparam int SYS_DIVIDE = 12;
  localparam int EXT_DIVIDE = 8;
  localparam logic [3:0] SYS_DIV_LAST = 4'(SYS_DIVIDE - 1);
  localparam logic [2:0] EXT_DIV_LAST = 3'(EXT_DIVIDE - 1);

  // ------------------------------------------------------------
  // Bus request carrier
  // ------------------------------------------------------------
  typedef struct packed {
    logic rd;
    logic wr;
    logic bit_wr;
    logic [2:0] bit_sel;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_type;

endpackage

// File: bench/timer_two_sva.sv
// Checker for the second timer's bus reads and interrupt request.
// Assumes it is bound to the timer block and sees only its ports.
module timer_two_sva (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire timer_two_pkg::sfr_req_type sfr_req,
  input wire logic [7:0] sfr_rdata,
  input wire logic timer_irq_enable,
  input wire logic timer_irq_req
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic ctrl_wr;
  logic mapped;
  assign ctrl_wr = (sfr_req.wr || sfr_req.bit_wr) && sfr_req.addr == 8'hC8;
  assign mapped = sfr_req.addr inside {8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD};
  chk_irq_needs_en: assert property (!timer_irq_enable |=> !timer_irq_req)
    else $error("irq without enable");
  chk_reset_zero: assert property ($fell(sys_rst) |-> !sfr_rdata && !timer_irq_req)
    else $error("outputs not zero after reset");
  chk_irq_holds: assert property (
    timer_irq_req && timer_irq_enable && !ctrl_wr && !$past(ctrl_wr) |=> timer_irq_req)
    else $error("flag cleared by hardware");
  chk_bit_one_zero: assert property (
    sfr_req.rd && sfr_req.addr == 8'hC8 |=> !sfr_rdata[1]) else $error("bit one set");
  chk_unmapped_zero: assert property (sfr_req.rd && !mapped |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_rdata_hold: assert property (!sfr_req.rd |=> $stable(sfr_rdata))
    else $error("read data moved");
  chk_ctrl_back: assert property (
    sfr_req.wr && sfr_req.addr == 8'hC8 ##1 sfr_req.rd && sfr_req.addr == 8'hC8
    |=> (sfr_rdata & 8'h3F) == ($past(sfr_req.wdata, 2) & 8'h3D)) else $error("control");
  chk_reload_back: assert property (
    sfr_req.wr && sfr_req.addr == 8'hCA ##1 sfr_req.rd && sfr_req.addr == 8'hCA
    |=> sfr_rdata == $past(sfr_req.wdata, 2)) else $error("reload low");
endmodule // timer_two_sva
bind timer_two_control_reload timer_two_sva u_sva (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .timer_irq_enable(timer_irq_enable),
  .timer_irq_req(timer_irq_req));

// File: bench/sfr_core_model.sv
// Processor core model driving one-cycle strobes on the register bus.
// Assumes every task is entered one time unit after a rising clock edge.
module sfr_core_model (
  input wire logic ref_clk,
  output timer_two_pkg::sfr_req_type sfr_req,
  input wire logic [7:0] sfr_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial sfr_req = '0;
  task automatic op(input logic r, w, b, input logic [2:0] s, input logic [7:0] a, d);
    sfr_req = {r, w, b, s, a, d};
    @(posedge ref_clk);
    #1;
  endtask
  task automatic idle();
    sfr_req = '0;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, d);
    op(1'b0, 1'b1, 1'b0, 3'h0, a, d);
  endtask
  // Software clears a flag with a single-bit write of zero.
  task automatic bw(input logic [2:0] s, input logic x);
    op(1'b0, 1'b0, 1'b1, s, 8'hC8, {7'h00, x});
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    op(1'b1, 1'b0, 1'b0, 3'h0, a, 8'h00);
    d = sfr_rdata;
  endtask
endmodule // sfr_core_model

// File: bench/tb_top.sv
// Self-checking bench for the second timer's control and reload logic.
// Assumes the core model and checker files are compiled before it.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic irq_en = 1'b0;
  logic hi_fast = 1'b0;
  logic lo_fast = 1'b0;
  logic ext_osc = 1'b0;
  logic slow_osc = 1'b1;
  logic irq;
  logic [7:0] rdata;
  logic [7:0] v;
  timer_two_pkg::sfr_req_type req;
  int miscompares = 0;
  int comparisons = 0;
  always #2.5 ref_clk = ~ref_clk;
  always #18.5 ext_osc = ~ext_osc;
  timer_two_control_reload u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .sfr_req(req),
    .sfr_rdata(rdata), .timer_irq_enable(irq_en), .high_byte_fast_clock_sel(hi_fast),
    .low_byte_fast_clock_sel(lo_fast), .ext_osc_clk(ext_osc), .slow_osc_clk(slow_osc),
    .timer_irq_req(irq));
  sfr_core_model u_core (.ref_clk(ref_clk), .sfr_req(req), .sfr_rdata(rdata));
  task automatic check(input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rc(input logic [7:0] a, e);
    u_core.rd(a, v);
    check(v, e);
  endtask
  task automatic test_done();
    if (miscompares == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic t_regs();
    rc(8'hC8, 8'h00);
    rc(8'hCA, 8'h00);
    rc(8'h55, 8'h00);
    u_core.wr(8'hC8, 8'h3A);
    rc(8'hC8, 8'h38);
    u_core.bw(3'h1, 1'b1);
    u_core.bw(3'h3, 1'b0);
    rc(8'hC8, 8'h30);
    u_core.wr(8'hCA, 8'hA5);
    rc(8'hCA, 8'hA5);
    u_core.wr(8'hC8, 8'h00);
  endtask
  task automatic t_wrap();
    lo_fast = 1'b1;
    irq_en = 1'b1;
    u_core.wr(8'hCA, 8'hFF);
    u_core.wr(8'hCB, 8'hFF);
    u_core.wr(8'hCC, 8'hFE);
    u_core.wr(8'hCD, 8'hFF);
    u_core.wr(8'hC8, 8'h04);
    repeat (4) u_core.idle();
    u_core.bw(3'h2, 1'b0);
    rc(8'hCD, 8'hFF);
    rc(8'hC8, 8'hC0);
    repeat (20) u_core.idle();
    check({7'h00, irq}, 8'h01);
    u_core.bw(3'h7, 1'b0);
    u_core.bw(3'h6, 1'b0);
    repeat (2) u_core.idle();
    check({7'h00, irq}, 8'h00);
  endtask
  task automatic t_split();
    hi_fast = 1'b1;
    u_core.wr(8'hCA, 8'hF0);
    u_core.wr(8'hCC, 8'hFE);
    u_core.wr(8'hCD, 8'h10);
    u_core.wr(8'hC8, 8'h28);
    repeat (4) u_core.idle();
    rc(8'hCD, 8'h10);
    rc(8'hC8, 8'h68);
    check({7'h00, irq}, 8'h01);
    u_core.wr(8'hC8, 8'h00);
    u_core.wr(8'hC8, 8'h00);
  endtask
  task automatic t_capture();
    u_core.wr(8'hCC, 8'h34);
    u_core.wr(8'hCD, 8'h12);
    u_core.wr(8'hC8, 8'h14);
    slow_osc = 1'b0;
    repeat (6) u_core.idle();
    u_core.bw(3'h2, 1'b0);
    rc(8'hCB, 8'h12);
    rc(8'hCA, 8'h36);
    rc(8'hC8, 8'h90);
    slow_osc = 1'b1;
    u_core.wr(8'hC8, 8'h00);
  endtask
  task automatic t_clocks();
    int e;
    lo_fast = 1'b0;
    for (int x = 0; x < 2; x++) begin
      u_core.wr(8'hCC, 8'h00);
      u_core.wr(8'hCD, 8'h00);
      u_core.wr(8'hC8, {7'h02, x[0]});
      repeat (600) u_core.idle();
      u_core.bw(3'h2, 1'b0);
      u_core.rd(8'hCC, v);
      e = x ? 10 : 50;
      check({7'h00, v >= e - 1 && v <= e + 1}, 8'h01);
    end
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    t_regs();
    t_wrap();
    t_split();
    t_capture();
    t_clocks();
    test_done();
  end
  initial begin
    #20000;
    miscompares++;
    test_done();
  end
endmodule // tb_top
